/* File: hw/bsl_top.sv */
// Board status lamp driver and sticky reset-cause register
// Assumes host I/O strobes are synchronous to clk, conditions are async pins
// Operation
// - Control value zero selects automatic lamp colour
// - Codes 08..0F map to off and seven colours
// - Automatic: red while board held in reset
// - Automatic: standby yellow, normal green, storage blue
// - Automatic: thermal white, held until shutdown
// - Automatic: cyan at 100 Mbps or stacking error
// - Automatic: magenta at 1000 Mbps, blink on traffic
// - Strap fitted at power-up forces red lamp in automatic mode
// - Configuration input enables or disables lamp
// - Cause read returns one per asserted source
// - Writing one clears exactly those cause bits
// - Bits 7..5: button, core, system supplies
// - Bits 4..0: io, main, mgmt, memory, standby
// - Priorities standby1, main/mgmt/mem2, io3, sys4, core5
// - Asserted source also sets higher-priority-number bits
// - Button bit sets whatever the button function
`timescale 1ns/1ps
`include "bsl_defines.svh"
module bsl_top
   import bsl_pkg::*;
#(
   parameter int unsigned BLINK_CYC = `BSL_BLINK_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire bsl_io_t io,
   input wire bsl_cond_t cond_pin,
   input wire bsl_rsrc_t rsrc_pin,
   input wire logic reset_indicator_strap,
   input wire logic lamp_enable,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic lamp_red,
   output logic lamp_green,
   output logic lamp_blue
);
   // Synchronised pins
   bsl_cond_t cond;
   bsl_rsrc_t rsrc;
   logic strap_s;
   logic lamp_en_s;

   // Phase of the strap capture after reset release
   typedef enum logic [1:0] {
      ST_WAIT,
      ST_WAIT2,
      ST_CAPTURE,
      ST_RUN
   } bsl_phase_t;

   // All state of this module
   typedef struct packed {
      bsl_phase_t phase;
      logic strap_seen;
      logic thermal_latch;
      logic [7:0] lamp_ctl;
      logic [7:0] cause;
      logic [31:0] blink_cnt;
      logic blink_ph;
      logic [7:0] rdata;
      logic rvalid;
      logic [2:0] rgb;
   } bsl_st_t;
   bsl_st_t st_q;
   bsl_st_t st_d;

   // Combinational helpers
   logic [7:0] set_vec;
   logic [2:0] auto_rgb;
   logic [2:0] sel_rgb;
   logic wr_lamp;
   logic wr_cause;
   logic rd_hit;

   // Pins cross into clk before use
   // Nine condition levels, eight sources, strap and enable
   bsl_sync #(.W(19)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .d({cond_pin, rsrc_pin, reset_indicator_strap, lamp_enable}),
      .q({cond, rsrc, strap_s, lamp_en_s})
   );

   // Priority spread: a source also sets every bit of higher priority number
   always_comb begin
      set_vec = 8'h00;
      set_vec[`BSL_RC_BUTTON] = rsrc[`BSL_RC_BUTTON];
      if (rsrc[`BSL_RC_STBY]) begin
         set_vec[6:0] = 7'h7f;
      end
      if (rsrc[`BSL_RC_MAIN] || rsrc[`BSL_RC_MGMT] || rsrc[`BSL_RC_MEM]) begin
         set_vec[6:4] = 3'h7;
         set_vec[3:1] = set_vec[3:1] | rsrc[3:1];
      end
      if (rsrc[`BSL_RC_IOC]) begin
         set_vec[6:4] = 3'h7;
      end
      if (rsrc[`BSL_RC_SYS]) begin
         set_vec[6:5] = 2'h3;
      end
      if (rsrc[`BSL_RC_CORE]) begin
         set_vec[`BSL_RC_CORE] = 1'b1;
      end
   end

   // Automatic colour, most urgent condition first
   always_comb begin
      if (st_q.strap_seen) begin
         auto_rgb = `BSL_RGB_RED;
      end else if (cond.in_reset) begin
         auto_rgb = `BSL_RGB_RED;
      end else if (st_q.thermal_latch) begin
         auto_rgb = `BSL_RGB_WHITE;
      end else if (cond.standby) begin
         auto_rgb = `BSL_RGB_YELLOW;
      end else if (cond.net_1000) begin
         // Traffic blanks the lamp on alternate half periods
         auto_rgb = (cond.net_act && st_q.blink_ph) ?
                    `BSL_RGB_OFF : `BSL_RGB_MAGENTA;
      end else if (cond.net_100 || cond.stack_err) begin
         auto_rgb = `BSL_RGB_CYAN;
      end else if (cond.storage_act) begin
         auto_rgb = `BSL_RGB_BLUE;
      end else begin
         auto_rgb = `BSL_RGB_GREEN;
      end
   end

   // Manual code or automatic, then the enable gate
   always_comb begin
      if (!lamp_en_s) begin
         sel_rgb = `BSL_RGB_OFF;
      end else if (st_q.lamp_ctl == `BSL_LAMP_AUTO) begin
         sel_rgb = auto_rgb;
      end else if (st_q.lamp_ctl[`BSL_LAMP_MAN_BIT]) begin
         // Low bits carry red, green, blue directly
         sel_rgb = {st_q.lamp_ctl[2], st_q.lamp_ctl[1],
                    st_q.lamp_ctl[0]};
      end else begin
         // Undefined codes leave the lamp dark
         sel_rgb = `BSL_RGB_OFF;
      end
   end

   // Address decode
   assign wr_lamp = io.wr && (io.addr == `BSL_ADDR_LAMP);
   assign wr_cause = io.wr && (io.addr == `BSL_ADDR_RCAUSE);
   assign rd_hit = io.rd && ((io.addr == `BSL_ADDR_LAMP) ||
                             (io.addr == `BSL_ADDR_RCAUSE));

   // Next state
   always_comb begin
      st_d = st_q;
      if (ce) begin
         // Strap is sampled once, after the synchroniser has filled;
         // an earlier look would only see its reset zero
         case (st_q.phase)
            ST_WAIT: begin
               st_d.phase = ST_WAIT2;
            end
            ST_WAIT2: begin
               st_d.phase = ST_CAPTURE;
            end
            ST_CAPTURE: begin
               st_d.strap_seen = strap_s;
               st_d.phase = ST_RUN;
            end
            ST_RUN: begin
               st_d.phase = ST_RUN;
            end
            default: begin
               st_d.phase = ST_WAIT;
            end
         endcase
         // Thermal white holds until shutdown
         if (cond.shutdown) begin
            st_d.thermal_latch = 1'b0;
         end else if (cond.thermal_near) begin
            st_d.thermal_latch = 1'b1;
         end
         // Blink timer
         if (st_q.blink_cnt >= BLINK_CYC - 1) begin
            st_d.blink_cnt = 32'h0000_0000;
            st_d.blink_ph = ~st_q.blink_ph;
         end else begin
            st_d.blink_cnt = st_q.blink_cnt + 32'h0000_0001;
         end
         // Lamp register, reserved bits dropped
         if (wr_lamp) begin
            st_d.lamp_ctl = {4'h0, io.wdata[3:0]};
         end
         // Sticky causes: set wins over the write-one clear
         if (wr_cause) begin
            st_d.cause = (st_q.cause & ~io.wdata) | set_vec;
         end else begin
            st_d.cause = st_q.cause | set_vec;
         end
         // Read port: one-cycle valid with registered data
         st_d.rvalid = rd_hit;
         if (io.rd && io.addr == `BSL_ADDR_RCAUSE) begin
            st_d.rdata = st_q.cause;
         end else if (io.rd && io.addr == `BSL_ADDR_LAMP) begin
            st_d.rdata = st_q.lamp_ctl;
         end else begin
            st_d.rdata = 8'h00;
         end
         st_d.rgb = sel_rgb;
      end
   end

   // Register; cause bits lose only power-on state, not board resets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.cause <= `BSL_RC_RST;
         st_q.lamp_ctl <= `BSL_LAMP_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign rvalid = st_q.rvalid;
   assign lamp_red = st_q.rgb[2];
   assign lamp_green = st_q.rgb[1];
   assign lamp_blue = st_q.rgb[0];

   // Checks
   AST_STBY_ALL: assert property (@(posedge clk) disable iff (!rst_n)
      ce && rsrc[0] |=> st_q.cause[6:0] == 7'h7f)
      else $error("standby cause did not set all prioritised bits");
   AST_CORE_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
      ce && rsrc == 8'h40 && !wr_cause |=> st_q.cause[6])
      else $error("core cause not recorded");
   AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      ce && wr_cause && set_vec == 8'h00
      |=> (st_q.cause & $past(io.wdata)) == 8'h00)
      else $error("write one did not clear cause bit");
   AST_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !wr_cause |=> (st_q.cause & $past(st_q.cause))
                          == $past(st_q.cause))
      else $error("cause bit dropped without a clear");
   AST_BUTTON: assert property (@(posedge clk) disable iff (!rst_n)
      ce && rsrc[7] |=> st_q.cause[7])
      else $error("button press not recorded");
   AST_READ: assert property (@(posedge clk) disable iff (!rst_n)
      ce && io.rd && io.addr == `BSL_ADDR_RCAUSE
      |=> rvalid && rdata == $past(st_q.cause))
      else $error("cause read mismatch");
   AST_MANUAL: assert property (@(posedge clk) disable iff (!rst_n)
      ce && lamp_en_s && st_q.lamp_ctl[3]
      |=> st_q.rgb == $past(st_q.lamp_ctl[2:0]))
      else $error("manual lamp code mismatch");
   AST_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !lamp_en_s |=> st_q.rgb == 3'h0)
      else $error("disabled lamp is lit");
   AST_RESET_RED: assert property (@(posedge clk) disable iff (!rst_n)
      ce && lamp_en_s && st_q.lamp_ctl == 8'h00 && cond.in_reset
      |=> st_q.rgb == 3'h4)
      else $error("reset not shown red");
   AST_THERM: assert property (@(posedge clk) disable iff (!rst_n)
      ce && st_q.thermal_latch && !cond.shutdown
      |=> st_q.thermal_latch)
      else $error("thermal latch released early");
endmodule

/* File: hw/bsl_defines.svh */
// Offsets, field positions, reset values and codes for the board status block
// Assumes inclusion by bare name from bsl_top and the testbench
`ifndef BSL_DEFINES_SVH
`define BSL_DEFINES_SVH
// Host I/O port addresses
`define BSL_ADDR_LAMP 16'h0984
`define BSL_ADDR_RCAUSE 16'h0987
// Lamp control register reset value and manual range
`define BSL_LAMP_RST 8'h00
`define BSL_LAMP_AUTO 8'h00
`define BSL_LAMP_MAN_BIT 3
// Reset-cause bit positions
`define BSL_RC_BUTTON 7
`define BSL_RC_CORE 6
`define BSL_RC_SYS 5
`define BSL_RC_IOC 4
`define BSL_RC_MAIN 3
`define BSL_RC_MGMT 2
`define BSL_RC_MEM 1
`define BSL_RC_STBY 0
`define BSL_RC_RST 8'h00
// Colour codes (red, green, blue emitters in bits 2..0)
`define BSL_RGB_OFF 3'h0
`define BSL_RGB_RED 3'h4
`define BSL_RGB_GREEN 3'h2
`define BSL_RGB_BLUE 3'h1
`define BSL_RGB_YELLOW 3'h6
`define BSL_RGB_CYAN 3'h3
`define BSL_RGB_MAGENTA 3'h5
`define BSL_RGB_WHITE 3'h7
// Traffic blink half period: 100 ms at 40 MHz
`define BSL_BLINK_MS 100
`define BSL_CLK_KHZ 40000
`define BSL_BLINK_CYC (`BSL_BLINK_MS * `BSL_CLK_KHZ)
`endif

/* File: hw/bsl_pkg.sv */
// Types shared by the board status block
// Assumes bsl_defines.svh is visible on the include path
package bsl_pkg;
   // Board condition levels, asynchronous at the pins
   typedef struct packed {
      logic in_reset;
      logic standby;
      logic storage_act;
      logic thermal_near;
      logic shutdown;
      logic net_100;
      logic net_1000;
      logic net_act;
      logic stack_err;
   } bsl_cond_t;
   // Reset source levels, in cause-bit order
   typedef logic [7:0] bsl_rsrc_t;
   // Host I/O access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } bsl_io_t;
endpackage

/* File: hw/bsl_sync.sv */
// Two-stage synchroniser for a vector of asynchronous levels
// Assumes one clock; first stage feeds only the second stage
`timescale 1ns/1ps
module bsl_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Both stages as one state struct
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bsl_sync_st_t;
   bsl_sync_st_t st_q;
   bsl_sync_st_t st_d;

   // Shift one stage per enabled edge
   always_comb begin
      st_d = st_q;
      if (ce) begin
         st_d.s1 = d;
         st_d.s2 = st_q.s1;
      end
   end

   // Constant reset only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule

/* File: tb/test_board_status_led_and_reset_flags.sv */
// Self-checking bench for the board status lamp and reset-cause block
// Assumes bsl_pkg, bsl_top and bsl_defines.svh compiled beforehand
`timescale 1ns/1ps
`include "bsl_defines.svh"
module test_board_status_led_and_reset_flags;
   import bsl_pkg::*;
   logic clk = 1'b0; // 40 MHz system clock
   logic rst_n = 1'b0; // Held low at start
   bsl_io_t io_s = '0; // Host port strobes
   bsl_cond_t cond_s = '0; // Board condition pins
   bsl_rsrc_t rsrc_s = '0; // Reset source pins
   logic strap = 1'b0; // Reset indicator jumper
   logic lamp_en = 1'b1; // Lamp enable setting
   logic [7:0] rdata;
   logic rvalid, lr, lg, lb;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int i, n_mag, n_off;
   logic [7:0] e;
   // Automatic-mode table: condition pins and expected colour
   logic [8:0] ac [0:10] = '{9'h000, 9'h040, 9'h001, 9'h008, 9'h004,
      9'h080, 9'h100, 9'h020, 9'h000, 9'h010, 9'h000};
   logic [2:0] ae [0:10] = '{3'h2, 3'h1, 3'h3, 3'h3, 3'h5, 3'h6, 3'h4,
      3'h7, 3'h7, 3'h2, 3'h2};

   // Clock: half period 12.5 ns
   always #12.5 clk = ~clk;

   // Short blink count keeps the traffic test brief
   bsl_top #(.BLINK_CYC(4)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .io(io_s), .cond_pin(cond_s), .rsrc_pin(rsrc_s),
      .reset_indicator_strap(strap), .lamp_enable(lamp_en),
      .rdata(rdata), .rvalid(rvalid), .lamp_red(lr), .lamp_green(lg),
      .lamp_blue(lb));

   // Single comparison point
   task check(string what, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Read one port; answer lands one edge after the strobe
   task rd(logic [15:0] a, logic [7:0] exp, logic v);
      io_s.rd = 1'b1;
      io_s.addr = a;
      @(posedge clk);
      #2 io_s.rd = 1'b0;
      check("rvalid", {7'h00, rvalid}, {7'h00, v});
      check("rdata", rdata, exp);
      @(posedge clk);
      #2;
   endtask

   // Write one port; extra edge keeps strobes from doubling up
   task wr(logic [15:0] a, logic [7:0] d);
      io_s.wr = 1'b1;
      io_s.addr = a;
      io_s.wdata = d;
      @(posedge clk);
      #2 io_s.wr = 1'b0;
      @(posedge clk);
      #2;
   endtask

   // Lamp check after sync and register delay
   task lamp(string what, logic [2:0] exp);
      repeat (6) @(posedge clk);
      #2 check(what, {5'h00, lr, lg, lb}, {5'h00, exp});
   endtask

   // Cause pattern a lone source should leave behind
   function automatic logic [7:0] spread(int k);
      case (k)
         0: return 8'h7F;
         1, 2, 3: return 8'h70 | (8'h01 << k);
         4: return 8'h70;
         5: return 8'h60;
         6: return 8'h40;
         default: return 8'h80;
      endcase
   endfunction

   // Counts, verdict and end of run
   task stop_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard, run needs well under this
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         stop_test;
      end
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      #2 rst_n = 1'b1;
      rd(`BSL_ADDR_LAMP, 8'h00, 1'b1);
      rd(`BSL_ADDR_RCAUSE, 8'h00, 1'b1);
      rd(16'h0985, 8'h00, 1'b0);
      $display("test reset values done");
      // Manual codes: emitters follow the low three bits
      for (i = 8; i < 16; i++) begin
         wr(`BSL_ADDR_LAMP, 8'(i));
         rd(`BSL_ADDR_LAMP, 8'(i), 1'b1);
         lamp("manual", 3'(i));
      end
      lamp_en = 1'b0;
      lamp("disabled", 3'h0);
      lamp_en = 1'b1;
      wr(`BSL_ADDR_LAMP, 8'h01);
      lamp("undefined code", 3'h0);
      $display("test manual lamp done");
      // Automatic colours, thermal hold released by shutdown
      wr(`BSL_ADDR_LAMP, 8'h00);
      for (i = 0; i < 11; i++) begin
         cond_s = ac[i];
         lamp("auto", ae[i]);
      end
      // Traffic at 1000 Mbps: both magenta and dark must show
      cond_s = 9'h006;
      repeat (6) @(posedge clk);
      n_mag = 0;
      n_off = 0;
      repeat (20) begin
         @(posedge clk);
         #2;
         if ({lr, lg, lb} === 3'h5) n_mag++;
         if ({lr, lg, lb} === 3'h0) n_off++;
      end
      check("blink", 8'(n_mag > 0 && n_off > 0), 8'h01);
      cond_s = '0;
      $display("test auto lamp done");
      // Each source alone, then hold, partial and full clears
      for (i = 0; i < 8; i++) begin
         e = spread(i);
         rsrc_s = 8'h01 << i;
         repeat (4) @(posedge clk);
         #2 rsrc_s = '0;
         repeat (4) @(posedge clk);
         #2 rd(`BSL_ADDR_RCAUSE, e, 1'b1);
         wr(`BSL_ADDR_RCAUSE, 8'h00);
         rd(`BSL_ADDR_RCAUSE, e, 1'b1);
         wr(`BSL_ADDR_RCAUSE, 8'h55);
         rd(`BSL_ADDR_RCAUSE, e & 8'hAA, 1'b1);
         wr(`BSL_ADDR_RCAUSE, 8'hFF);
         rd(`BSL_ADDR_RCAUSE, 8'h00, 1'b1);
      end
      $display("test reset cause done");
      // Power-up with jumper fitted shows red though running
      strap = 1'b1;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #2 rst_n = 1'b1;
      lamp("strap", 3'h4);
      $display("test strap done");
      stop_test;
   end
endmodule
